/* File: logic/cfg_chain_pkg.sv */
// Constants, states and carriers for the configuration-chain control block.
// Assumes a 40 MHz core clock; link pins arrive asynchronously.
package cfg_chain_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 25;
    localparam int RELOAD_MIN_NS     = 500;
    localparam int RELOAD_MIN_CYC    = (RELOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BITCLK_MAX_NS     = 200;
    localparam int CD2CU_PERIODS     = 4;
    localparam int CD2CU_CYC         =
        (CD2CU_PERIODS * BITCLK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int USER_INIT_PERIODS = 3192;
    localparam int OSC_REVERT_EDGES  = 10;
    localparam int CD2UM_US          = 300;
    localparam int CD2UM_CYC         = (CD2UM_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W             = 14;
    localparam int RLD_W             = 6;
    localparam int REV_W             = 4;

    // ------------------------------------------------------------------
    // Data path and synchroniser layout
    // ------------------------------------------------------------------
    localparam int WORD_W  = 8;
    localparam int NBIT_W  = 3;
    localparam int SY_BCLK = 0;
    localparam int SY_UCLK = 1;
    localparam int SY_RLD  = 2;
    localparam int SY_CE   = 3;
    localparam int SY_DONE = 4;
    localparam int SY_STAT = 5;
    localparam int SY_SCH  = 6;
    localparam int SY_DATA = 8;
    localparam int SYNC_W  = SY_DATA + WORD_W;

    typedef enum logic [2:0] {
        ST_RESET     = 3'h0,
        ST_LOAD      = 3'h1,
        ST_WAIT_DONE = 3'h3,
        ST_INIT      = 3'h2,
        ST_USER      = 3'h6
    } cfg_state_t;

    typedef enum logic [1:0] {
        SCH_SERIAL_FLASH   = 2'h0,
        SCH_PARALLEL_FLASH = 2'h1,
        SCH_HOST_SERIAL    = 2'h2,
        SCH_HOST_PARALLEL  = 2'h3
    } scheme_t;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic              last;
    } cfg_word_t;

    typedef struct packed {
        logic o;
        logic oe;
    } od_pin_t;

endpackage

/* File: logic/cfg_chain_ctrl.sv */
// Configuration load control for one device of a daisy chain.
// Assumes open-drain lines resolved outside and test-port decode on MCLK.
`timescale 1ns/1ps

module cfg_chain_ctrl #(
    parameter int FRAME_WORDS = 16,
    parameter int INIT_CYC    = cfg_chain_pkg::CD2UM_CYC
) (
    input  wire logic                             MCLK,
    input  wire logic                             RST_B,
    input  wire logic                             CFG_BIT_CLOCK,
    input  wire logic [cfg_chain_pkg::WORD_W-1:0] CFG_DATA,
    input  wire logic                             CHIP_ENABLE_IN_B,
    input  wire logic                             RELOAD_REQUEST_B,
    input  wire logic                             USER_SUPPLIED_CLOCK,
    input  wire logic [1:0]                       SCHEME,
    input  wire logic                             LOAD_COMPLETE_I,
    input  wire logic                             CONFIG_STATUS_I,
    input  wire logic                             TP_LOAD_EN,
    input  wire logic                             TP_BIT_VALID,
    input  wire logic                             TP_BIT,
    input  wire logic                             PULSE_RELOAD_INSTR,
    input  wire logic                             ENGAGE_INSTR,
    input  wire logic                             SELECT_USER_CLOCK_INSTR,
    input  wire logic                             SELECT_OSC_CLOCK_INSTR,
    input  wire logic                             USER_CLK_OPT,
    input  wire logic                             REMOTE_UPDATE_EN,
    input  wire logic                             ERR_DETECT_EN,
    input  wire logic                             WORD_READY,
    output cfg_chain_pkg::cfg_word_t              WORD_OUT,
    output logic                                  WORD_VALID,
    output cfg_chain_pkg::od_pin_t                LOAD_COMPLETE_DRV,
    output cfg_chain_pkg::od_pin_t                CONFIG_STATUS_DRV,
    output logic                                  CHAIN_ENABLE_OUT_B,
    output logic                                  OSC_ENABLE,
    output logic                                  CTRL_CLK_SEL_USER,
    output logic                                  USER_CLK_EN,
    output logic                                  USER_MODE,
    output logic                                  ACTIVE_ENGAGED,
    output logic                                  LOAD_ERROR
);
    import cfg_chain_pkg::*;

    localparam int WCNT_W = $clog2(FRAME_WORDS + 1);

    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic              bclk_d_ff;
    logic              uclk_d_ff;
    logic              bclk_rise;
    logic              uclk_rise;
    scheme_t           scheme;
    logic              is_active;
    logic              ce_high;
    cfg_state_t        state_ff;
    cfg_state_t        nxt_state;
    logic [RLD_W-1:0]  rld_cnt_ff;
    logic              ignore_rld_ff;
    logic              restart;
    logic              stat_err;
    logic [CNT_W-1:0]  cnt_ff;
    logic              init_end;
    logic              tp_take;
    logic              pin_take;
    logic              take;
    logic              ser_bit;
    logic              par_word;
    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] word_now;
    logic [NBIT_W-1:0] nbits_ff;
    logic [WCNT_W-1:0] wcnt_ff;
    logic              frame_done_ff;
    logic              pend_ff;
    cfg_word_t         pend_word_ff;
    cfg_word_t         slot1_ff;
    logic              slot1_v_ff;
    logic              buf_room;
    logic              push;
    logic              pop;
    logic [2:0]        own_stat_ff;
    logic              rev_pend_ff;
    logic [REV_W-1:0]  rev_cnt_ff;

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    assign async_in = {CFG_DATA, SCHEME, CONFIG_STATUS_I, LOAD_COMPLETE_I,
                       CHIP_ENABLE_IN_B, RELOAD_REQUEST_B,
                       USER_SUPPLIED_CLOCK, CFG_BIT_CLOCK};

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_ff  <= '0;
            sync2_ff  <= '0;
            bclk_d_ff <= 1'b0;
            uclk_d_ff <= 1'b0;
        end else begin
            sync1_ff  <= async_in;
            sync2_ff  <= sync1_ff;
            bclk_d_ff <= sync2_ff[SY_BCLK];
            uclk_d_ff <= sync2_ff[SY_UCLK];
        end
    end

    // Edges are found only from pin activity, so the bit clock may stop
    // for any length of time without a timeout firing.
    assign bclk_rise = sync2_ff[SY_BCLK] & ~bclk_d_ff;
    assign uclk_rise = sync2_ff[SY_UCLK] & ~uclk_d_ff;
    assign scheme    = scheme_t'(sync2_ff[SY_SCH +: 2]);
    assign is_active = (scheme == SCH_SERIAL_FLASH) || (scheme == SCH_PARALLEL_FLASH);
    assign ce_high   = sync2_ff[SY_CE];

    // ------------------------------------------------------------------
    // Reload request, engage and restart
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rld_cnt_ff <= '0;
        end else if (sync2_ff[SY_RLD]) begin
            rld_cnt_ff <= '0;
        end else if (rld_cnt_ff != RLD_W'(RELOAD_MIN_CYC)) begin
            rld_cnt_ff <= rld_cnt_ff + RLD_W'(1);
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            ignore_rld_ff <= 1'b0;
        end else if (ENGAGE_INSTR) begin
            ignore_rld_ff <= 1'b1;
        end
    end

    // Giving the parallel-flash bus away disengages the controller, and
    // the reload pin never brings it back.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            ACTIVE_ENGAGED <= 1'b1;
        end else if (ENGAGE_INSTR) begin
            ACTIVE_ENGAGED <= 1'b1;
        end else if (scheme == SCH_PARALLEL_FLASH && ce_high) begin
            ACTIVE_ENGAGED <= 1'b0;
        end
    end

    // Our own status drive comes back through the synchroniser a few edges
    // late; masking it keeps a restart from reading as another device's error.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            own_stat_ff <= '0;
        end else begin
            own_stat_ff <= {own_stat_ff[1:0], CONFIG_STATUS_DRV.oe};
        end
    end

    assign stat_err = (state_ff == ST_LOAD) && !sync2_ff[SY_STAT] && !(|own_stat_ff);
    // Engage restarts in every scheme like a pulse-reload, and also sets
    // ignore_rld_ff so the reload pin is ignored from then on.
    assign restart  = ((rld_cnt_ff == RLD_W'(RELOAD_MIN_CYC)) && !ignore_rld_ff)
                    || PULSE_RELOAD_INSTR || ENGAGE_INSTR || stat_err;

    // ------------------------------------------------------------------
    // Load sequence
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (restart) begin
            nxt_state = ST_RESET;
        end else begin
            case (state_ff)
                ST_RESET: begin
                    // Waiting for reload release lets a second master own the bus.
                    if (sync2_ff[SY_RLD] && (ACTIVE_ENGAGED || !is_active)) begin
                        nxt_state = ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (frame_done_ff) begin
                        nxt_state = ST_WAIT_DONE;
                    end
                end
                ST_WAIT_DONE: begin
                    if (sync2_ff[SY_DONE]) begin
                        nxt_state = ST_INIT;
                    end
                end
                ST_INIT: begin
                    if (init_end) begin
                        nxt_state = ST_USER;
                    end
                end
                default: nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Initialization timing
    // ------------------------------------------------------------------
    assign init_end = (state_ff == ST_INIT) && (USER_CLK_OPT ?
        (USER_CLK_EN && uclk_rise && cnt_ff == CNT_W'(USER_INIT_PERIODS - 1)) :
        (cnt_ff == CNT_W'(INIT_CYC - 1)));

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_ff      <= '0;
            USER_CLK_EN <= 1'b0;
        end else if (nxt_state != ST_INIT && nxt_state != ST_USER) begin
            cnt_ff      <= '0;
            USER_CLK_EN <= 1'b0;
        end else if (state_ff != ST_INIT) begin
            cnt_ff      <= '0;
        end else if (!USER_CLK_OPT) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end else if (!USER_CLK_EN) begin
            if (cnt_ff == CNT_W'(CD2CU_CYC - 1)) begin
                USER_CLK_EN <= 1'b1;
                cnt_ff      <= '0;
            end else begin
                cnt_ff <= cnt_ff + CNT_W'(1);
            end
        end else if (uclk_rise) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Bit capture
    // ------------------------------------------------------------------
    // Only the bit clock, or TP_BIT_VALID on the test port, paces the load; the flash wait line is not an input.
    assign tp_take  = (state_ff == ST_LOAD) && TP_LOAD_EN && TP_BIT_VALID;
    assign pin_take = (state_ff == ST_LOAD) && !ce_high && bclk_rise
                    && !TP_LOAD_EN;
    assign take     = (tp_take || pin_take) && !frame_done_ff;
    assign ser_bit  = tp_take ? TP_BIT : sync2_ff[SY_DATA];
    assign par_word = (scheme == SCH_HOST_PARALLEL) && !tp_take;
    assign word_now = par_word ? sync2_ff[SY_DATA +: WORD_W]
                               : {shift_ff[WORD_W-2:0], ser_bit};

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            shift_ff      <= '0;
            nbits_ff      <= '0;
            wcnt_ff       <= '0;
            frame_done_ff <= 1'b0;
            pend_ff       <= 1'b0;
            pend_word_ff  <= '0;
            LOAD_ERROR    <= 1'b0;
        end else if (state_ff == ST_RESET) begin
            nbits_ff      <= '0;
            wcnt_ff       <= '0;
            frame_done_ff <= 1'b0;
            LOAD_ERROR    <= 1'b0;
        end else begin
            if (push) begin
                pend_ff <= 1'b0;
            end
            if (take) begin
                shift_ff <= word_now;
                nbits_ff <= nbits_ff + NBIT_W'(1);
                if (par_word || nbits_ff == NBIT_W'(WORD_W - 1)) begin
                    nbits_ff          <= '0;
                    pend_ff           <= 1'b1;
                    pend_word_ff.data <= word_now;
                    pend_word_ff.last <= (wcnt_ff == WCNT_W'(FRAME_WORDS - 1));
                    wcnt_ff           <= wcnt_ff + WCNT_W'(1);
                    if (pend_ff && !buf_room) begin
                        LOAD_ERROR <= 1'b1;
                    end
                    if (wcnt_ff == WCNT_W'(FRAME_WORDS - 1)) begin
                        frame_done_ff <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------------
    assign buf_room = !slot1_v_ff;
    assign push     = pend_ff && buf_room;
    assign pop      = WORD_VALID && WORD_READY;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            WORD_OUT   <= '0;
            WORD_VALID <= 1'b0;
            slot1_ff   <= '0;
            slot1_v_ff <= 1'b0;
        end else if (pop && slot1_v_ff) begin
            WORD_OUT <= slot1_ff;
            if (push) begin
                slot1_ff <= pend_word_ff;
            end else begin
                slot1_v_ff <= 1'b0;
            end
        end else if (pop) begin
            if (push) begin
                WORD_OUT <= pend_word_ff;
            end else begin
                WORD_VALID <= 1'b0;
            end
        end else if (push) begin
            if (!WORD_VALID) begin
                WORD_OUT   <= pend_word_ff;
                WORD_VALID <= 1'b1;
            end else begin
                slot1_ff   <= pend_word_ff;
                slot1_v_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared lines and mode outputs
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            LOAD_COMPLETE_DRV  <= '{o: 1'b0, oe: 1'b1};
            CONFIG_STATUS_DRV  <= '{o: 1'b0, oe: 1'b0};
            CHAIN_ENABLE_OUT_B <= 1'b1;
            USER_MODE          <= 1'b0;
            OSC_ENABLE         <= 1'b1;
        end else begin
            LOAD_COMPLETE_DRV.oe <= (nxt_state == ST_RESET)
                                 || (nxt_state == ST_LOAD);
            CONFIG_STATUS_DRV.oe <= !ce_high && (nxt_state == ST_RESET);
            CHAIN_ENABLE_OUT_B   <= (nxt_state == ST_RESET) || (nxt_state == ST_LOAD);
            USER_MODE            <= (nxt_state == ST_USER);
            OSC_ENABLE           <= (nxt_state != ST_USER) || restart
                                 || REMOTE_UPDATE_EN || ERR_DETECT_EN;
        end
    end

    // ------------------------------------------------------------------
    // Controller clock source
    // ------------------------------------------------------------------
    // The selection survives reload and restart; only RST_B or SELECT_OSC_CLOCK_INSTR clears it.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            CTRL_CLK_SEL_USER <= 1'b0;
            rev_pend_ff       <= 1'b0;
            rev_cnt_ff        <= '0;
        end else if (SELECT_USER_CLOCK_INSTR && OSC_ENABLE) begin
            CTRL_CLK_SEL_USER <= 1'b1;
            rev_pend_ff       <= 1'b0;
        end else if (SELECT_OSC_CLOCK_INSTR && CTRL_CLK_SEL_USER) begin
            rev_pend_ff <= 1'b1;
            rev_cnt_ff  <= '0;
        end else if (rev_pend_ff && uclk_rise) begin
            rev_cnt_ff <= rev_cnt_ff + REV_W'(1);
            if (rev_cnt_ff == REV_W'(OSC_REVERT_EDGES - 1)) begin
                CTRL_CLK_SEL_USER <= 1'b0;
                rev_pend_ff       <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    a_chain_after_load: assert property (
        state_ff == ST_WAIT_DONE |-> !CHAIN_ENABLE_OUT_B)
        else $error("chain enable not low after load");

    a_done_released: assert property (
        !CHAIN_ENABLE_OUT_B |-> !LOAD_COMPLETE_DRV.oe)
        else $error("done line still driven after chain enable");

    a_done_held: assert property (
        state_ff == ST_LOAD |-> LOAD_COMPLETE_DRV.oe && !LOAD_COMPLETE_DRV.o)
        else $error("done line not held low while loading");

    a_init_entry: assert property (
        state_ff == ST_WAIT_DONE && sync2_ff[SY_DONE] && !restart
        |=> state_ff == ST_INIT)
        else $error("initialization not entered on done high");

    a_uclk_delay: assert property (
        $rose(USER_CLK_EN) |-> $past(cnt_ff) == CNT_W'(CD2CU_CYC - 1)
        && state_ff == ST_INIT)
        else $error("user clock enabled at wrong time");

    a_user_entry: assert property (
        state_ff == ST_INIT && USER_CLK_OPT && nxt_state == ST_USER
        |-> USER_CLK_EN && cnt_ff == CNT_W'(USER_INIT_PERIODS - 1))
        else $error("user mode entered at wrong user clock count");

    a_reload_ignored: assert property (
        ignore_rld_ff && state_ff == ST_USER && !PULSE_RELOAD_INSTR
        && !ENGAGE_INSTR |=> state_ff == ST_USER)
        else $error("reload pin acted after engage");

    a_osc_off_user: assert property (
        USER_MODE && $past(!REMOTE_UPDATE_EN && !ERR_DETECT_EN && !restart)
        |-> !OSC_ENABLE)
        else $error("oscillator left on in user mode");

    a_clk_sel_gate: assert property (
        SELECT_USER_CLOCK_INSTR && !OSC_ENABLE && !CTRL_CLK_SEL_USER
        |=> !CTRL_CLK_SEL_USER)
        else $error("clock switched with oscillator off");

    a_ce_quiet: assert property (
        $past(ce_high) |-> !CONFIG_STATUS_DRV.oe)
        else $error("status driven while chip enable high");

endmodule

/* File: sim/host_model.sv */
// Host model: drives the bit clock and serial data of the load link.
// Assumes the bench calls send_byte once the device has left reset.
`timescale 1ns/1ps
module host_model (
    output logic       BCLK,
    output logic [7:0] DATA,
    input  wire logic  STAT_I
);
    bit started;
    initial begin
        BCLK = 1'b0;
        DATA = 8'h00;
    end
    // ----
    // Byte transfer
    // ----
    // Sends one byte, most significant bit first, with an optional pause mid-byte.
    task automatic send_byte(input logic [7:0] b, input int pause_ns);
        if (!started) begin
            wait (STAT_I === 1'b1);
            #2000;
            started = 1'b1;
        end
        for (int i = 7; i >= 0; i--) begin
            DATA[0] = b[i];
            #100 BCLK = 1'b1;
            #100 BCLK = 1'b0;
            if (i == 4) #(pause_ns);
        end
        DATA = ~DATA;
    endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the configuration-chain control block.
// Assumes the host model on the bit link and a held-low chain done line.
`timescale 1ns/1ps
module tb_top;
    import cfg_chain_pkg::*;
    localparam int INIT_N = 20;
    logic       mclk, rst_b, bclk, ce_b, rld_b, uclk, rem, pulse, engage, sel_u, ready, hold;
    logic [7:0] data, b0, b1;
    logic [1:0] scheme;
    cfg_word_t  wout;
    od_pin_t    ldrv, sdrv;
    logic       wval, ceo_b, osc, csel, ucen, umode, eng, lerr;
    logic       sel_o, tp_en, tp_v, tp_b, uopt;
    int         bad_count, checks_done, n;
    host_model i_host (.BCLK(bclk), .DATA(data), .STAT_I(!sdrv.oe));
    cfg_chain_ctrl #(.FRAME_WORDS(2), .INIT_CYC(INIT_N)) i_dut (
        .MCLK(mclk), .RST_B(rst_b), .CFG_BIT_CLOCK(bclk), .CFG_DATA(data),
        .CHIP_ENABLE_IN_B(ce_b), .RELOAD_REQUEST_B(rld_b), .USER_SUPPLIED_CLOCK(uclk),
        .SCHEME(scheme), .LOAD_COMPLETE_I(!ldrv.oe && !hold), .CONFIG_STATUS_I(!sdrv.oe),
        .TP_LOAD_EN(tp_en), .TP_BIT_VALID(tp_v), .TP_BIT(tp_b), .PULSE_RELOAD_INSTR(pulse),
        .ENGAGE_INSTR(engage), .SELECT_USER_CLOCK_INSTR(sel_u), .SELECT_OSC_CLOCK_INSTR(sel_o),
        .USER_CLK_OPT(uopt), .REMOTE_UPDATE_EN(rem), .ERR_DETECT_EN(rem), .WORD_READY(ready),
        .WORD_OUT(wout), .WORD_VALID(wval), .LOAD_COMPLETE_DRV(ldrv), .CONFIG_STATUS_DRV(sdrv),
        .CHAIN_ENABLE_OUT_B(ceo_b), .OSC_ENABLE(osc), .CTRL_CLK_SEL_USER(csel),
        .USER_CLK_EN(ucen), .USER_MODE(umode), .ACTIVE_ENGAGED(eng), .LOAD_ERROR(lerr));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        uclk = 1'b0;
        forever #100 uclk = ~uclk;
    end
    function automatic cfg_word_t expw(input logic [7:0] b, input logic l);
        expw = '{data: b, last: l};
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #1ms;
        bad_count++;
        final_report();
    end
    initial begin
        {rst_b, ce_b, rem, pulse, engage, sel_u, ready} = '0;
        {sel_o, tp_en, tp_v, tp_b, uopt} = '0;
        {rld_b, hold} = 2'b11;
        scheme = SCH_HOST_SERIAL;
        void'($urandom(32'h91851c7f));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        tick(2);
        chk(ceo_b, 1'b1);
        chk(ldrv.oe, 1'b1);
        chk(osc, 1'b1);
        rst_b = 1'b1;
        ce_b = 1'b1;
        i_host.send_byte(~b0, 0);
        tick(6);
        chk(wval, 1'b0);
        chk(sdrv.oe, 1'b0);
        ce_b = 1'b0;
        tick(6);
        i_host.send_byte(b0, 3000);
        i_host.send_byte(b1, 0);
        tick(8);
        chk(ceo_b, 1'b0);
        chk(ldrv.oe, 1'b0);
        chk(lerr, 1'b0);
        chk(wout, expw(b0, 1'b0));
        ready = 1'b1;
        tick(1);
        ready = 1'b0;
        tick(1);
        chk(wout, expw(b1, 1'b1));
        ready = 1'b1;
        tick(1);
        ready = 1'b0;
        tick(40);
        chk(wval, 1'b0);
        chk(umode, 1'b0);
        hold = 1'b0;
        for (int i = 0; i < INIT_N + 60 && umode !== 1'b1; i++) tick(1);
        chk(umode, 1'b1);
        chk(osc, 1'b0);
        sel_u = 1'b1;
        tick(1);
        sel_u = 1'b0;
        rem = 1'b1;
        tick(3);
        chk(csel, 1'b0);
        chk(osc, 1'b1);
        sel_u = 1'b1;
        tick(1);
        sel_u = 1'b0;
        tick(2);
        chk(csel, 1'b1);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) pulse = 1'b1;
            else engage = 1'b1;
            tick(1);
            {pulse, engage} = 2'b00;
            tick(3);
            chk(umode, 1'b0);
            chk(ldrv.oe, 1'b1);
            rld_b = 1'b0;
            tick(30);
            chk(sdrv.oe, 1'(k == 0));
            chk(csel, 1'b1);
            rld_b = 1'b1;
            tick(10);
        end
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        {tp_en, tp_v, uopt} = 3'b111;
        for (int i = 0; i < 16; i++) begin
            tp_b = (i < 8) ? b0[3'(7 - i)] : b1[3'(15 - i)];
            tick(1);
        end
        {tp_en, tp_v} = 2'b00;
        tick(4);
        chk(ceo_b, 1'b0);
        chk(wout, expw(b0, 1'b0));
        ready = 1'b1;
        tick(1);
        ready = 1'b0;
        tick(1);
        chk(wout, expw(b1, 1'b1));
        chk(ucen, 1'b0);
        for (int i = 0; i < 60 && ucen !== 1'b1; i++) tick(1);
        chk(ucen, 1'b1);
        chk(umode, 1'b0);
        n = 0;
        while (umode !== 1'b1 && n < 26000) begin
            tick(1);
            n++;
        end
        chk(umode, 1'b1);
        chk(9'(n > 25000), 9'h001);
        rld_b = 1'b0;
        tick(30);
        chk(umode, 1'b1);
        rld_b = 1'b1;
        sel_o = 1'b1;
        tick(1);
        sel_o = 1'b0;
        tick(5);
        chk(csel, 1'b1);
        tick(100);
        chk(csel, 1'b0);
        final_report();
    end
endmodule
